// ---- design/spindle_warning_map.svh ----
// Register offsets, field layouts, codes and timing for the spindle warning reporter
`ifndef SPINDLE_WARNING_MAP_SVH
`define SPINDLE_WARNING_MAP_SVH

// Register byte offsets
`define OFF_CODE_LOW 8'h00
`define OFF_CODE_HIGH 8'h04
`define OFF_DIAG_SP1 8'h08
`define OFF_DIAG_SP2 8'h0C
`define OFF_DIAG_SP3 8'h10
`define OFF_DIAG_SP4 8'h14
`define OFF_CONFIG 8'h18
`define OFF_IRQ_STATUS 8'h1C
`define OFF_IRQ_CLEAR 8'h20
`define OFF_IRQ_ENABLE 8'h24
`define OFF_ALARM 8'h28

// Config register fields
`define CFG_PRESENT_LSB 0
`define CFG_OLDER_LSB 4
`define CFG_RESISTOR_LSB 8
`define CFG_RESET 12'h000

// Interrupt status fields
`define IRQ_CODE_CHANGE_BIT 0
`define IRQ_ALARM_LSB 1
`define IRQ_RESET 5'h00

// Warning numbers
`define WCODE_NONE 9'h000
`define WCODE_INT_FAN 9'd56
`define WCODE_RAD_FAN 9'd88
`define WCODE_OPEN_PHASE 9'd4
`define WCODE_CONV_OVERLOAD 9'd58
`define WCODE_CONV_FAN 9'd59
`define WCODE_CONV_RAD_FAN 9'd113

// Timing
`define CLK_PERIOD_NS 10
`define SCAN_TICK_NS 1000000
`define ALARM_LONG_S 60
`define ALARM_SHORT_S 5
`define TICKS_PER_S 1000

`endif

// ---- design/spindle_warning_pkg.sv ----
// Types for the spindle warning reporter
`include "spindle_warning_map.svh"

package spindle_warning_pkg;

   typedef logic [8:0] wcode_t;

   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [16:0] div;
      logic tick;
      logic [11:0] cfg;
      wcode_t wcode;
      logic [3:0][8:0] diag;
      logic [3:0][15:0] tmr;
      logic [3:0] alarm;
      logic [4:0] irq_st;
      logic [4:0] irq_en;
      logic irq;
      logic [31:0] rdata;
   } state_t;

endpackage

// ---- design/spindle_warning_reporter.sv ----
// Spindle warning reporter: per-spindle warning codes, priority select, alarm timers
//
// Contract
// - Code bits one to eight on low byte bits 0..7, bit nine on high byte bit 0.
// - A warning qualifying spindle shows its nine-bit warning number on the code outputs.
// - Several spindles warning: the lowest axis number wins.
// - No qualifying spindle, or any older spindle configured: reporting off for all.
// - Internal fan stop reports 56, keeps running, alarm about one minute later.
// - Radiator fan stop reports 88, alarm only when main circuit overheats.
// - Open phase reports 04, alarm after one minute, or five seconds for resistor supply.
// - Converter overload reports 58, alarm about one minute later.
// - Converter fan stop reports 59, alarm about one minute later.
// - Converter radiator fan stop reports 113, alarm only on converter overheat.
// - Per-spindle diagnostic status holds the current code, zero when none.
//
// Implementation choices: the address-and-strobe port and the address map.

`include "spindle_warning_map.svh"
`timescale 1ns/1ps
`default_nettype none

module spindle_warning_reporter #(
   parameter int TICK_CYCLES = `SCAN_TICK_NS / `CLK_PERIOD_NS,
   parameter int LONG_TICKS = `ALARM_LONG_S * `TICKS_PER_S,
   parameter int SHORT_TICKS = `ALARM_SHORT_S * `TICKS_PER_S
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [31:0] rd_data_out,
   // Amplifier and supply conditions, one bit per spindle
   input wire logic [3:0] int_fan_stop_in,
   input wire logic [3:0] rad_fan_stop_in,
   input wire logic [3:0] open_phase_in,
   input wire logic [3:0] conv_overload_in,
   input wire logic [3:0] conv_fan_stop_in,
   input wire logic [3:0] conv_rad_fan_stop_in,
   input wire logic [3:0] main_overheat_in,
   input wire logic [3:0] conv_overheat_in,
   // Signal bytes to the logic controller
   output logic [7:0] warn_code_low_out,
   output logic [7:0] warn_code_high_out,
   // Alarms and interrupt
   output logic [3:0] alarm_out,
   output logic irq_out
);
   import spindle_warning_pkg::*;

   state_t q;
   state_t d;

   // Synchronised condition bits, spindle index within each kind
   logic [3:0] int_fan;
   logic [3:0] rad_fan;
   logic [3:0] open_ph;
   logic [3:0] overload;
   logic [3:0] conv_fan;
   logic [3:0] conv_rad;
   logic [3:0] main_hot;
   logic [3:0] conv_hot;

   assign int_fan = q.sync2[3:0];
   assign rad_fan = q.sync2[7:4];
   assign open_ph = q.sync2[11:8];
   assign overload = q.sync2[15:12];
   assign conv_fan = q.sync2[19:16];
   assign conv_rad = q.sync2[23:20];
   assign main_hot = q.sync2[27:24];
   assign conv_hot = q.sync2[31:28];

   logic [3:0] present;
   logic [3:0] older;
   logic [3:0] resistor;
   logic [3:0] qualify;
   logic enable;

   assign present = q.cfg[`CFG_PRESENT_LSB +: 4];
   assign older = q.cfg[`CFG_OLDER_LSB +: 4];
   assign resistor = q.cfg[`CFG_RESISTOR_LSB +: 4];
   assign qualify = present & ~older;
   assign enable = (qualify != 4'h0) && ((present & older) == 4'h0);

   // Per-spindle warning code, timed flag and alarm limit
   wcode_t code_w [4];
   logic [3:0] timed_w;
   logic [3:0] hot_alarm_w;
   logic [15:0] limit_w [4];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_spindle
         always_comb begin
            code_w[gi] = `WCODE_NONE;
            if (open_ph[gi]) begin
               code_w[gi] = `WCODE_OPEN_PHASE;
            end else if (overload[gi]) begin
               code_w[gi] = `WCODE_CONV_OVERLOAD;
            end else if (conv_fan[gi]) begin
               code_w[gi] = `WCODE_CONV_FAN;
            end else if (conv_rad[gi]) begin
               code_w[gi] = `WCODE_CONV_RAD_FAN;
            end else if (int_fan[gi]) begin
               code_w[gi] = `WCODE_INT_FAN;
            end else if (rad_fan[gi]) begin
               code_w[gi] = `WCODE_RAD_FAN;
            end
         end
         // Warnings that escalate on elapsed time
         assign timed_w[gi] = open_ph[gi] | overload[gi] | conv_fan[gi] | int_fan[gi];
         // Fan warnings that escalate only on overheat
         assign hot_alarm_w[gi] = (rad_fan[gi] & main_hot[gi]) |
                                  (conv_rad[gi] & conv_hot[gi]);
         assign limit_w[gi] = (open_ph[gi] && resistor[gi]) ?
                              16'(SHORT_TICKS) : 16'(LONG_TICKS);
      end
   endgenerate

   always_comb begin
      wcode_t sel;
      logic [3:0] alarm_set;
      logic [4:0] irq_set;
      sel = `WCODE_NONE;
      alarm_set = 4'h0;
      irq_set = 5'h00;
      d = q;

      // Two-stage synchroniser on all condition pins
      d.sync1 = {conv_overheat_in, main_overheat_in, conv_rad_fan_stop_in,
                 conv_fan_stop_in, conv_overload_in, open_phase_in,
                 rad_fan_stop_in, int_fan_stop_in};
      d.sync2 = q.sync1;

      // Scan tick divider
      d.tick = 1'b0;
      if (q.div == 17'(TICK_CYCLES - 1)) begin
         d.div = 17'h00000;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 17'h00001;
      end

      // Lowest axis number wins
      for (int i = 3; i >= 0; i--) begin
         if (qualify[i] && code_w[i] != `WCODE_NONE) begin
            sel = code_w[i];
         end
      end
      if (!enable) begin
         sel = `WCODE_NONE;
      end
      if (q.tick) begin
         d.wcode = sel;
      end
      if (d.wcode != q.wcode) begin
         irq_set[`IRQ_CODE_CHANGE_BIT] = 1'b1;
      end

      for (int i = 0; i < 4; i++) begin
         // Diagnostic status per spindle
         d.diag[i] = (enable && qualify[i]) ? code_w[i] : `WCODE_NONE;
         // Alarm timers count scan ticks while a timed warning lasts
         if (enable && qualify[i] && timed_w[i]) begin
            if (q.tick && q.tmr[i] < limit_w[i]) begin
               d.tmr[i] = q.tmr[i] + 16'h0001;
            end
            if (q.tmr[i] >= limit_w[i]) begin
               alarm_set[i] = 1'b1;
            end
         end else begin
            d.tmr[i] = 16'h0000;
         end
         if (enable && qualify[i] && hot_alarm_w[i]) begin
            alarm_set[i] = 1'b1;
         end
      end
      irq_set[`IRQ_ALARM_LSB +: 4] = alarm_set & ~q.alarm;

      // Register writes; hardware set wins over software clear
      if (wr_en_in && addr_in == `OFF_CONFIG) begin
         d.cfg = wr_data_in[11:0];
      end
      if (wr_en_in && addr_in == `OFF_IRQ_ENABLE) begin
         d.irq_en = wr_data_in[4:0];
      end
      if (wr_en_in && addr_in == `OFF_IRQ_CLEAR) begin
         d.irq_st = (q.irq_st & ~wr_data_in[4:0]) | irq_set;
      end else begin
         d.irq_st = q.irq_st | irq_set;
      end
      if (wr_en_in && addr_in == `OFF_ALARM) begin
         d.alarm = (q.alarm & ~wr_data_in[3:0]) | alarm_set;
      end else begin
         d.alarm = q.alarm | alarm_set;
      end
      d.irq = (d.irq_st & d.irq_en) != 5'h00;

      // Read data for one cycle only
      d.rdata = 32'h00000000;
      if (rd_en_in) begin
         if (addr_in == `OFF_CODE_LOW) begin
            d.rdata = {24'h000000, q.wcode[7:0]};
         end else if (addr_in == `OFF_CODE_HIGH) begin
            d.rdata = {31'h00000000, q.wcode[8]};
         end else if (addr_in == `OFF_DIAG_SP1) begin
            d.rdata = {23'h000000, q.diag[0]};
         end else if (addr_in == `OFF_DIAG_SP2) begin
            d.rdata = {23'h000000, q.diag[1]};
         end else if (addr_in == `OFF_DIAG_SP3) begin
            d.rdata = {23'h000000, q.diag[2]};
         end else if (addr_in == `OFF_DIAG_SP4) begin
            d.rdata = {23'h000000, q.diag[3]};
         end else if (addr_in == `OFF_CONFIG) begin
            d.rdata = {20'h00000, q.cfg};
         end else if (addr_in == `OFF_IRQ_STATUS) begin
            d.rdata = {27'h0000000, q.irq_st};
         end else if (addr_in == `OFF_IRQ_ENABLE) begin
            d.rdata = {27'h0000000, q.irq_en};
         end else if (addr_in == `OFF_ALARM) begin
            d.rdata = {28'h0000000, q.alarm};
         end
      end

      if (!rstn_in) begin
         d = '0;
         d.cfg = `CFG_RESET;
         d.irq_st = `IRQ_RESET;
         d.wcode = `WCODE_NONE;
      end
   end

   always_ff @(posedge clk_in) begin
      q <= d;
   end

   // Outputs straight from state
   assign warn_code_low_out = q.wcode[7:0];
   assign warn_code_high_out = {7'h00, q.wcode[8]};
   assign alarm_out = q.alarm;
   assign irq_out = q.irq;
   assign rd_data_out = q.rdata;

endmodule // spindle_warning_reporter

`default_nettype wire

// ---- sim/plc_reader_model.sv ----
// Logic controller model that reads the two warning signal bytes
`timescale 1ns/1ps
`default_nettype none
module plc_reader_model (
   // Clock
   input wire logic clk_in,
   // Signal bytes
   input wire logic [7:0] low_in,
   input wire logic [7:0] high_in,
   // Decoded code and act request
   output logic [8:0] code_out,
   output logic act_out
);
   always_ff @(posedge clk_in) begin
      code_out <= {high_in[0], low_in};
      act_out <= |{high_in[0], low_in};
   end
endmodule // plc_reader_model
`default_nettype wire

// ---- sim/spindle_warning_reporter_checker.sv ----
// Checker for the spindle warning reporter ports
`timescale 1ns/1ps
`default_nettype none
module spindle_warning_reporter_checker #(
   parameter int TICK_CYCLES = 4
) (
   // Clock, reset and register port
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [31:0] rd_data_out,
   // Warning causes
   input wire logic [3:0] int_fan_stop_in,
   input wire logic [3:0] rad_fan_stop_in,
   input wire logic [3:0] open_phase_in,
   input wire logic [3:0] conv_overload_in,
   input wire logic [3:0] conv_fan_stop_in,
   input wire logic [3:0] conv_rad_fan_stop_in,
   // Observed outputs
   input wire logic [7:0] warn_code_low_out,
   input wire logic [7:0] warn_code_high_out,
   input wire logic [3:0] alarm_out
);
   logic [7:0] cfg_q, off_q, quiet_q;
   logic clr_q, en, any;
   logic [8:0] code;
   assign code = {warn_code_high_out[0], warn_code_low_out};
   assign en = |(cfg_q[3:0] & ~cfg_q[7:4]) && !(|(cfg_q[3:0] & cfg_q[7:4]));
   assign any = |{int_fan_stop_in, rad_fan_stop_in, open_phase_in, conv_overload_in,
      conv_fan_stop_in, conv_rad_fan_stop_in};
   always_ff @(posedge clk_in) begin
      clr_q <= rstn_in && wr_en_in && addr_in == 8'h28 && |wr_data_in[3:0];
      if (!rstn_in) cfg_q <= 8'h00;
      else if (wr_en_in && addr_in == 8'h18) cfg_q <= wr_data_in[7:0];
      if (!rstn_in || en) off_q <= 8'h00;
      else if (off_q != 8'hFF) off_q <= off_q + 8'h01;
      if (!rstn_in || any) quiet_q <= 8'h00;
      else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   high_bits_zero_a: assert property (warn_code_high_out[7:1] == 7'h00)
      else $error("high signal byte has spare bits set");
   low_read_a: assert property (rd_en_in && addr_in == 8'h00 |=>
      rd_data_out == {24'h000000, $past(warn_code_low_out)}) else $error("low byte read wrong");
   high_read_a: assert property (rd_en_in && addr_in == 8'h04 |=>
      rd_data_out[0] == $past(warn_code_high_out[0])) else $error("ninth bit read wrong");
   code_legal_a: assert property (code inside {9'h000, 9'h004, 9'h038, 9'h03A, 9'h03B,
      9'h058, 9'h071}) else $error("code outside the warning set");
   code_hold_a: assert property ($changed(code) |=> $stable(code) [*2])
      else $error("code changed between scans");
   off_zero_a: assert property (off_q >= 2 * TICK_CYCLES + 2 |-> code == 9'h000)
      else $error("code shown while reporting off");
   quiet_zero_a: assert property (quiet_q >= 2 * TICK_CYCLES + 4 |-> code == 9'h000)
      else $error("code shown with no warning");
   read_idle_a: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h00000000)
      else $error("read data outside its cycle");
   alarm_sticky_a: assert property (|(~alarm_out & $past(alarm_out)) |-> clr_q)
      else $error("alarm dropped without clear");
endmodule // spindle_warning_reporter_checker
bind spindle_warning_reporter spindle_warning_reporter_checker #(.TICK_CYCLES(TICK_CYCLES))
   chk_inst (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
   .int_fan_stop_in(int_fan_stop_in), .rad_fan_stop_in(rad_fan_stop_in),
   .open_phase_in(open_phase_in), .conv_overload_in(conv_overload_in),
   .conv_fan_stop_in(conv_fan_stop_in), .conv_rad_fan_stop_in(conv_rad_fan_stop_in),
   .warn_code_low_out(warn_code_low_out), .warn_code_high_out(warn_code_high_out),
   .alarm_out(alarm_out));
`default_nettype wire

// ---- sim/spindle_warning_reporter_test.sv ----
// Testbench for the spindle warning reporter
`timescale 1ns/1ps
`default_nettype none
module spindle_warning_reporter_test;
   localparam int TK = 4;
   localparam logic [8:0] CD [0:5] = '{9'h038, 9'h058, 9'h004, 9'h03A, 9'h03B, 9'h071};
   localparam int ORD [0:5] = '{2, 3, 4, 5, 0, 1};
   localparam logic [11:0] CF [0:3] = '{12'h00F, 12'h01F, 12'h000, 12'h00A};
   logic clk_in, rstn_in, wr_en, rd_en, act, irq;
   logic [7:0] addr, lo, hi;
   logic [31:0] wdata, rdata, d;
   logic [3:0] ip [0:5];
   logic [3:0] mo, co, alarm;
   logic [8:0] code;
   logic [11:0] cfg;
   int fail_count, n_checks, seed, cnt;
   spindle_warning_reporter #(.TICK_CYCLES(TK), .LONG_TICKS(6), .SHORT_TICKS(3))
      spindle_warning_reporter_inst (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr),
      .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
      .int_fan_stop_in(ip[0]), .rad_fan_stop_in(ip[1]), .open_phase_in(ip[2]),
      .conv_overload_in(ip[3]), .conv_fan_stop_in(ip[4]), .conv_rad_fan_stop_in(ip[5]),
      .main_overheat_in(mo), .conv_overheat_in(co), .warn_code_low_out(lo),
      .warn_code_high_out(hi), .alarm_out(alarm), .irq_out(irq));
   plc_reader_model plc_reader_model_inst (.clk_in(clk_in), .low_in(lo), .high_in(hi),
      .code_out(code), .act_out(act));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [8:0] sp_code(int i);
      for (int k = 0; k < 6; k++) if (ip[ORD[k]][i]) return CD[ORD[k]];
      return 9'h000;
   endfunction
   function automatic logic qual(int i);
      return cfg[i] && !cfg[4+i] && !(|(cfg[3:0] & cfg[7:4]));
   endfunction
   function automatic logic [8:0] exp_rep();
      for (int i = 0; i < 4; i++) if (qual(i) && sp_code(i) != 9'h000) return sp_code(i);
      return 9'h000;
   endfunction
   task automatic waitc(int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk_in);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(logic [31:0] g, logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h want %h", $time, g, e);
         fail_count++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      seed = 10;
      fail_count = 0;
      n_checks = 0;
      {rstn_in, wr_en, rd_en, addr, wdata, mo, co, cfg} = '0;
      for (int j = 0; j < 6; j++) ip[j] = 4'h0;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(8'h18, d);
      chk(d, 32'h0);
      rd(8'h00, d);
      chk(d, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 46; k++) begin
         cfg = (k < 6) ? 12'h00F : CF[k%4];
         wr(8'h18, {20'h0, cfg});
         for (int j = 0; j < 6; j++)
            ip[j] <= (k < 6) ? ((j == k) ? 4'h8 : 4'h0) : 4'($random(seed) & $random(seed));
         waitc(3 * TK);
         chk({23'h0, code}, {23'h0, exp_rep()});
         for (int i = 0; i < 4; i++) begin
            rd(8'(8 + 4 * i), d);
            chk(d, {23'h0, qual(i) ? sp_code(i) : 9'h000});
         end
      end
      $display("test codes done");
      for (int j = 0; j < 6; j++) ip[j] <= 4'h0;
      waitc(4);
      wr(8'h28, 32'hF);
      wr(8'h20, 32'h1F);
      wr(8'h24, 32'h02);
      for (int j = 0; j < 2; j++) begin
         wr(8'h18, j ? 32'h00F : 32'h10F);
         ip[2] <= 4'h1;
         cnt = 0;
         while (alarm[0] !== 1'b1 && cnt < 200) begin
            @(posedge clk_in);
            cnt++;
         end
         if (cnt >= 200) begin
            $display("unexpected at %0t: alarm wait ran out", $time);
            fail_count++;
         end else begin
            chk(cnt < 21, j == 0);
            chk(irq, 1'b1);
         end
         ip[2] <= 4'h0;
         waitc(4);
         wr(8'h28, 32'h1);
         wr(8'h20, 32'h1F);
         waitc(2);
         chk({alarm, irq}, 5'h00);
      end
      $display("test alarms done");
      for (int j = 0; j < 2; j++) begin
         ip[j ? 5 : 1] <= 4'h2;
         waitc(40);
         chk(alarm[1], 1'b0);
         if (j) co <= 4'h2;
         else mo <= 4'h2;
         waitc(8);
         chk(alarm[1], 1'b1);
         ip[j ? 5 : 1] <= 4'h0;
         mo <= 4'h0;
         co <= 4'h0;
         waitc(4);
         wr(8'h28, 32'hF);
      end
      $display("test overheat done");
      close_out();
   end
endmodule // spindle_warning_reporter_test
`default_nettype wire
